// file: rtl/pfs_port_sideband.sv
// Behaviour
// R1 - rx fail on discard of started bad packet
// R2 - rx abort flushes current receive packet
// R3 - host asserts abort only with rx select
// R4 - half duplex flow control forces collisions
// R5 - full duplex flow control sends pause
// R6 - release sends zero pause if enabled
// R7 - tx ready drivers enabled by tx control
// R8 - rx ready drivers enabled by rx control
// R9 - tx ready when free space meets threshold
// R10 - tx ready held low until error read
// R11 - rx ready on threshold or end in fifo
// R12 - rx ready optionally on header present
// R13 - rx ready pulses with rx fail
// R14 - rx keep retains last read data
// R15 - status word follows end of packet
// R16 - ready lines float while enable deasserted
// R17 - thresholds and pause settings per port
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "pfs_defines.svh"
module pfs_port_sideband (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // host bus pins
  input wire logic txctl_n,
  input wire logic rxctl_n,
  input wire logic rxsel_n,
  input wire logic rx_abort,
  input wire logic rx_keep,
  input wire logic [7:0] flow_ctl,
  input wire logic [2:0] rd_port,
  input wire logic rd_strobe,
  input wire logic rd_eop,
  output logic [7:0] tx_ready_o,
  output logic [7:0] tx_ready_oe,
  output logic [7:0] rx_ready_o,
  output logic [7:0] rx_ready_oe,
  output logic rx_fail,
  output logic [31:0] bus_data_o,
  output logic bus_data_oe,
  // fifo core side
  input wire logic [71:0] tx_free_lvl,
  input wire logic [71:0] rx_fill_lvl,
  input wire logic [7:0] rx_eop_in,
  input wire logic [7:0] rx_hdr_in,
  input wire logic [7:0] rx_bad_discard,
  input wire logic [7:0] rx_started,
  input wire logic [7:0] tx_err_stop,
  input wire logic [31:0] rx_data_in,
  input wire logic [31:0] rx_status_in,
  output logic [7:0] rx_flush,
  output logic [7:0] rx_pop,
  // mac side
  output logic [7:0] force_col,
  output logic [7:0] pause_req,
  output logic [15:0] pause_time
);
  pfs_pkg::pfs_st_t s_reg;
  pfs_pkg::pfs_st_t s_next;
  logic [15:0] mem_rdata;
  logic mem_we;
  logic [2:0] mem_ra;

  function automatic logic meets(input pfs_pkg::pfs_lvl_t lvl,
                                 input pfs_pkg::pfs_lvl_t thr);
    meets = (lvl >= thr);
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] v);
    lowest = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 3'(i);
      end
    end
  endfunction

  function automatic logic in_blk(input logic [7:0] a, input logic [2:0] b);
    in_blk = (a[7:5] == b);
  endfunction

  pfs_pause_mem u_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .we(mem_we),
    .waddr(paddr[4:2]),
    .wdata(pwdata[15:0]),
    .raddr(mem_ra),
    .rdata(mem_rdata)
  );

  always_comb begin
    logic apb_mrd;
    logic done;
    logic [7:0] fail_p;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [2:0] p;
    apb_mrd = 1'b0;
    done = 1'b0;
    fail_p = 8'h00;
    rise = 8'h00;
    fall = 8'h00;
    p = 3'h0;
    s_next = s_reg;
    mem_we = 1'b0;
    mem_ra = paddr[4:2];
    // apb: one read cycle for the pause memory, answer after two waits
    case (s_reg.ap)
      pfs_pkg::AP_IDLE: begin
        if (psel && penable) begin
          apb_mrd = 1'b1;
          s_next.ap = pfs_pkg::AP_WAIT;
        end
      end
      pfs_pkg::AP_WAIT: begin
        s_next.ap = pfs_pkg::AP_DONE;
        s_next.pready = 1'b1;
        s_next.pslverr = 1'b0;
        s_next.prdata = 32'h0000_0000;
        if (in_blk(paddr, `PFS_THR_BASE)) begin
          s_next.prdata[8:0] = s_reg.tx_thr[paddr[4:2]];
          s_next.prdata[`PFS_THR_RX_LSB +: 9] = s_reg.rx_thr[paddr[4:2]];
        end else if (in_blk(paddr, `PFS_PAUSE_BASE)) begin
          s_next.prdata[15:0] = mem_rdata;
        end else begin
          case (paddr)
            `PFS_CTRL_OFS:
              s_next.prdata[23:0] = {s_reg.hdr_en, s_reg.zp_en, s_reg.fd};
            `PFS_IRQ_STS_OFS: s_next.prdata[15:0] = s_reg.irq_sts;
            `PFS_IRQ_MSK_OFS: s_next.prdata[15:0] = s_reg.irq_msk;
            `PFS_LEVEL_OFS:
              s_next.prdata[15:0] = {s_reg.rx_rdy, s_reg.tx_rdy};
            `PFS_TXERR_OFS: s_next.prdata[7:0] = s_reg.tx_hold;
            default: s_next.pslverr = 1'b1;
          endcase
        end
      end
      pfs_pkg::AP_DONE: begin
        done = 1'b1;
        s_next.ap = pfs_pkg::AP_IDLE;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
      end
      default: s_next.ap = pfs_pkg::AP_IDLE;
    endcase
    if (done && pwrite && !s_reg.pslverr) begin
      if (in_blk(paddr, `PFS_THR_BASE)) begin
        s_next.tx_thr[paddr[4:2]] = pwdata[8:0]; // R17
        s_next.rx_thr[paddr[4:2]] = pwdata[`PFS_THR_RX_LSB +: 9]; // R17
      end else if (in_blk(paddr, `PFS_PAUSE_BASE)) begin
        mem_we = 1'b1; // R17
      end else begin
        case (paddr)
          `PFS_CTRL_OFS: begin
            s_next.fd = pwdata[`PFS_CTRL_FD_LSB +: 8];
            s_next.zp_en = pwdata[`PFS_CTRL_ZP_LSB +: 8]; // R17
            s_next.hdr_en = pwdata[`PFS_CTRL_HDR_LSB +: 8];
          end
          `PFS_IRQ_STS_OFS: s_next.irq_sts = s_reg.irq_sts & ~pwdata[15:0];
          `PFS_IRQ_MSK_OFS: s_next.irq_msk = pwdata[15:0];
          default: ;
        endcase
      end
    end
    // only the holds that the read returned are released
    if (done && !pwrite && paddr == `PFS_TXERR_OFS) begin
      s_next.tx_hold = s_reg.tx_hold & ~s_reg.prdata[7:0]; // R10
    end
    // flow control; pins are synchronous, no synchroniser needed
    s_next.flct_q = flow_ctl;
    rise = flow_ctl & ~s_reg.flct_q & s_reg.fd; // R5
    fall = ~flow_ctl & s_reg.flct_q & s_reg.fd & s_reg.zp_en; // R6
    s_next.force_col = flow_ctl & ~s_reg.fd; // R4
    s_next.pause_req = 8'h00;
    if (s_reg.seq_busy) begin
      s_next.seq_busy = 1'b0;
      s_next.pause_req[s_reg.seq_port] = 1'b1; // R5
      s_next.pause_time = s_reg.seq_zero ? 16'h0000 : mem_rdata; // R6
    end else if ((|s_reg.pend) && !apb_mrd) begin
      // apb has the read port first; a pause waits one cycle at most
      p = lowest(s_reg.pend);
      mem_ra = p;
      s_next.pend[p] = 1'b0;
      s_next.seq_busy = 1'b1;
      s_next.seq_port = p;
      s_next.seq_zero = !flow_ctl[p] && s_reg.zp_en[p]; // R6
    end
    s_next.pend = s_next.pend | rise | fall;
    // ready lines
    fail_p = rx_bad_discard & rx_started; // R1
    s_next.tx_hold = s_next.tx_hold | tx_err_stop; // R10
    s_next.tx_oe = !txctl_n; // R7
    s_next.rx_oe = !rxctl_n; // R8
    for (int i = 0; i < 8; i++) begin
      s_next.tx_rdy[i] = !txctl_n && !s_next.tx_hold[i] && // R16
        meets(tx_free_lvl[i*9 +: 9], s_reg.tx_thr[i]); // R9
      s_next.rx_rdy[i] = !rxctl_n && // R16
        (meets(rx_fill_lvl[i*9 +: 9], s_reg.rx_thr[i]) || // R11
         rx_eop_in[i] || // R11
         (s_reg.hdr_en[i] && rx_hdr_in[i]) || // R12
         fail_p[i]); // R13
    end
    s_next.rx_fail = |fail_p; // R1
    // receive side strobes, honoured only under rx select
    s_next.rx_flush = 8'h00;
    s_next.rx_pop = 8'h00;
    s_next.bus_oe = 1'b0;
    if (!rxsel_n && rx_abort) begin
      s_next.rx_flush[rd_port] = 1'b1; // R2 R3
    end
    if (!rxsel_n && rd_strobe) begin
      s_next.rx_pop[rd_port] = !rx_keep; // R14
      s_next.bus_oe = 1'b1;
      s_next.bus_data = s_reg.after_eop ? rx_status_in : rx_data_in; // R15
      s_next.after_eop = rd_eop && !s_reg.after_eop; // R15
    end
    // interrupts: set wins over a clearing write
    s_next.irq_sts = s_next.irq_sts | {tx_err_stop, fail_p};
    s_next.irq = |(s_next.irq_sts & s_reg.irq_msk);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.tx_thr <= {8{`PFS_THR_RST}};
      s_reg.rx_thr <= {8{`PFS_THR_RST}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq = s_reg.irq;
  assign tx_ready_o = s_reg.tx_rdy;
  assign tx_ready_oe = {8{s_reg.tx_oe}};
  assign rx_ready_o = s_reg.rx_rdy;
  assign rx_ready_oe = {8{s_reg.rx_oe}};
  assign rx_fail = s_reg.rx_fail;
  assign bus_data_o = s_reg.bus_data;
  assign bus_data_oe = s_reg.bus_oe;
  assign rx_flush = s_reg.rx_flush;
  assign rx_pop = s_reg.rx_pop;
  assign force_col = s_reg.force_col;
  assign pause_req = s_reg.pause_req;
  assign pause_time = s_reg.pause_time;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // one port stands for all; the logic is per-port bitwise or one per-port loop, except the shared lowest-port-first pause sequencer
  sequence fd_rise3;
    s_reg.fd[3] && $rose(flow_ctl[3]);
  endsequence
  sequence pause_out3;
    ##[1:40] pause_req[3];
  endsequence
  sequence fd_fall3;
    s_reg.fd[3] && s_reg.zp_en[3] && $fell(flow_ctl[3]);
  endsequence

  rx_fail_a: assert property ( // R1
    (|(rx_bad_discard & rx_started)) |=> rx_fail)
    else $error("rx fail missing after discard");
  abort_flush_a: assert property ( // R2
    (!rxsel_n && rx_abort) |=> rx_flush[$past(rd_port)])
    else $error("abort did not flush");
  sel_gate_a: assert property ( // R3
    rxsel_n |=> (rx_flush == 8'h00 && rx_pop == 8'h00 && !bus_data_oe))
    else $error("receive strobe honoured without select");
  col_force_a: assert property ( // R4
    (!s_reg.fd[2] && flow_ctl[2]) |=> force_col[2])
    else $error("collision not forced");
  col_full_a: assert property ( // R4
    s_reg.fd[3] |=> !force_col[3])
    else $error("collision forced in full duplex");
  pause_send_a: assert property (fd_rise3 |-> pause_out3) // R5
    else $error("pause frame not requested");
  // a quick re-rise before service sends the programmed time instead
  zero_pause_a: assert property ( // R6
    fd_fall3 ##1 (!flow_ctl[3])[*3]
    |-> ##[0:40] (pause_req[3] && pause_time == 16'h0000))
    else $error("zero pause not sent");
  tx_enable_a: assert property ( // R7
    txctl_n |=> (tx_ready_oe == 8'h00 && tx_ready_o == 8'h00))
    else $error("tx ready driven while disabled");
  rx_enable_a: assert property ( // R8
    rxctl_n |=> (rx_ready_oe == 8'h00 && rx_ready_o == 8'h00))
    else $error("rx ready driven while disabled");
  tx_thresh_a: assert property ( // R9
    (!txctl_n && !s_reg.tx_hold[0] && !tx_err_stop[0]
     && tx_free_lvl[8:0] >= s_reg.tx_thr[0]) |=> tx_ready_o[0])
    else $error("tx ready missing above threshold");
  tx_below_a: assert property ( // R9
    (tx_free_lvl[8:0] < s_reg.tx_thr[0]) |=> !tx_ready_o[0])
    else $error("tx ready set below threshold");
  tx_hold_a: assert property ( // R10
    tx_err_stop[0] |=> (!tx_ready_o[0])[*3])
    else $error("tx ready not held after error");
  rx_thresh_a: assert property ( // R11
    (!rxctl_n && (rx_fill_lvl[26:18] >= s_reg.rx_thr[2] || rx_eop_in[2]))
    |=> rx_ready_o[2])
    else $error("rx ready missing at threshold or end");
  hdr_ready_a: assert property ( // R12
    (!rxctl_n && s_reg.hdr_en[0] && rx_hdr_in[0]) |=> rx_ready_o[0])
    else $error("rx ready missing with header");
  fail_pair_a: assert property ( // R13
    (!rxctl_n && rx_bad_discard[1] && rx_started[1])
    |=> (rx_fail && rx_ready_o[1]))
    else $error("rx ready not paired with rx fail");
  keep_pop_a: assert property ( // R14
    (!rxsel_n && rd_strobe && rx_keep) |=> (rx_pop == 8'h00))
    else $error("kept read consumed fifo data");
  read_pop_a: assert property ( // R14
    (!rxsel_n && rd_strobe && !rx_keep) |=> rx_pop[$past(rd_port)])
    else $error("read did not consume fifo data");
  eop_mark_a: assert property ( // R15
    (!rxsel_n && rd_strobe && rd_eop && !s_reg.after_eop) |=> s_reg.after_eop)
    else $error("eop access not remembered");
  eop_hold_a: assert property ( // R15
    (s_reg.after_eop && (rxsel_n || !rd_strobe)) |=> s_reg.after_eop)
    else $error("eop mark lost before next access");
  eop_status_a: assert property ( // R15
    (!rxsel_n && rd_strobe && s_reg.after_eop)
    |=> (bus_data_oe && bus_data_o == $past(rx_status_in)))
    else $error("status word missing after eop");
  // the answer stands one cycle, so a held request is not served twice
  pready_once_a: assert property (
    pready |=> !pready)
    else $error("pready stood longer than one cycle");
endmodule

// file: rtl/pfs_defines.svh
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_NPORT 8
`define PFS_LVLW 9
`define PFS_CTRL_OFS 8'h00
`define PFS_IRQ_STS_OFS 8'h04
`define PFS_IRQ_MSK_OFS 8'h08
`define PFS_LEVEL_OFS 8'h0C
`define PFS_TXERR_OFS 8'h10
`define PFS_THR_BASE 3'h1
`define PFS_PAUSE_BASE 3'h2
`define PFS_CTRL_FD_LSB 0
`define PFS_CTRL_ZP_LSB 8
`define PFS_CTRL_HDR_LSB 16
`define PFS_THR_RX_LSB 16
`define PFS_IRQ_TX_LSB 8
`define PFS_THR_RST 9'h040
`define PFS_PAUSE_RST 16'hFFFF
`define PFS_PAUSE_WAIT 40
`endif

// file: rtl/pfs_pkg.sv
`include "pfs_defines.svh"
package pfs_pkg;
  typedef enum logic [1:0] {AP_IDLE, AP_WAIT, AP_DONE} pfs_apb_t;
  typedef logic [`PFS_LVLW-1:0] pfs_lvl_t;
  typedef struct packed {
    logic [`PFS_NPORT-1:0][15:0] mem;
    logic [15:0] rdata;
  } pfs_mem_st_t;
  typedef struct packed {
    pfs_apb_t ap;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] fd;
    logic [7:0] zp_en;
    logic [7:0] hdr_en;
    logic [7:0][8:0] tx_thr;
    logic [7:0][8:0] rx_thr;
    logic [15:0] irq_sts;
    logic [15:0] irq_msk;
    logic irq;
    logic [7:0] tx_hold;
    logic [7:0] flct_q;
    logic [7:0] pend;
    logic seq_busy;
    logic [2:0] seq_port;
    logic seq_zero;
    logic [7:0] pause_req;
    logic [15:0] pause_time;
    logic [7:0] tx_rdy;
    logic tx_oe;
    logic [7:0] rx_rdy;
    logic rx_oe;
    logic [7:0] force_col;
    logic [7:0] rx_flush;
    logic [7:0] rx_pop;
    logic rx_fail;
    logic after_eop;
    logic [31:0] bus_data;
    logic bus_oe;
  } pfs_st_t;
endpackage

// file: rtl/pfs_pause_mem.sv
`timescale 1ns/10ps
`include "pfs_defines.svh"
module pfs_pause_mem (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // write port
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [15:0] wdata,
  // read port, data one cycle later
  input wire logic [2:0] raddr,
  output logic [15:0] rdata
);
  pfs_pkg::pfs_mem_st_t s_reg;
  pfs_pkg::pfs_mem_st_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = s_reg.mem[raddr];
    if (we) begin
      s_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= {(`PFS_NPORT + 1){`PFS_PAUSE_RST}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
endmodule

// file: tb/pfs_host_model.sv
`timescale 1ns/10ps
module pfs_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // requests from the bench
  input wire logic go,
  input wire logic abort_req,
  input wire logic eop_req,
  input wire logic keep_req,
  // host bus pins
  output logic rxsel_n,
  output logic rx_abort,
  output logic rd_strobe,
  output logic rd_eop,
  output logic rx_keep
);
  // abort and keep only ever ride inside a select cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxsel_n <= 1'h1;
      rx_abort <= 1'h0;
      rd_strobe <= 1'h0;
      rd_eop <= 1'h0;
      rx_keep <= 1'h0;
    end else begin
      rxsel_n <= !go;
      rx_abort <= go & abort_req;
      rd_strobe <= go & !abort_req;
      rd_eop <= go & eop_req;
      rx_keep <= go & keep_req;
    end
  end
endmodule

// file: tb/pfs_port_sideband_test.sv
`timescale 1ns/10ps
module pfs_port_sideband_test;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, rx_fail, bus_data_oe, err, irq_a;
  logic txctl_n = 1'h1, rxctl_n = 1'h1;
  logic rxsel_n, rx_abort, rx_keep, rd_strobe, rd_eop;
  logic go = 1'h0, abort_req = 1'h0, eop_req = 1'h0, keep_req = 1'h0;
  logic [7:0] flow_ctl = 8'h00, rx_bad_discard = 8'h00, rx_started = 8'h00;
  logic [7:0] tx_err_stop = 8'h00, rx_eop_in = 8'h00, rx_hdr_in = 8'h00;
  logic [2:0] rd_port = 3'h5;
  logic [71:0] tx_free_lvl = 72'h0, rx_fill_lvl = 72'h0;
  logic [31:0] rx_data_in = 32'hA5A5_0001, rx_status_in = 32'h5A5A_0002;
  logic [7:0] tx_ready_o, tx_ready_oe, rx_ready_o, rx_ready_oe;
  logic [7:0] rx_flush, rx_pop, force_col, pause_req;
  logic [15:0] pause_time;
  logic [31:0] bus_data_o;
  int errors = 0, n_compared = 0;

  always #10 ref_clk = !ref_clk;

  pfs_port_sideband dut (.ref_clk, .arst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .txctl_n, .rxctl_n,
    .rxsel_n, .rx_abort, .rx_keep, .flow_ctl, .rd_port, .rd_strobe, .rd_eop,
    .tx_ready_o, .tx_ready_oe, .rx_ready_o, .rx_ready_oe, .rx_fail,
    .bus_data_o, .bus_data_oe, .tx_free_lvl, .rx_fill_lvl, .rx_eop_in,
    .rx_hdr_in, .rx_bad_discard, .rx_started, .tx_err_stop, .rx_data_in,
    .rx_status_in, .rx_flush, .rx_pop, .force_col, .pause_req, .pause_time);

  pfs_host_model host (.ref_clk, .arst_n, .go, .abort_req, .eop_req,
    .keep_req, .rxsel_n, .rx_abort, .rd_strobe, .rd_eop, .rx_keep);

  task print_verdict;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // master holds everything until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    // look once settled, then release at the edge that samples pready
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      #1;
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    @(posedge ref_clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task hread(input logic a, input logic e, input logic k);
    @(posedge ref_clk);
    go <= 1'h1;
    abort_req <= a;
    eop_req <= e;
    keep_req <= k;
    @(posedge ref_clk);
    go <= 1'h0;
    tk(1);
  endtask

  task wt_pause(input logic [15:0] t);
    int i;
    for (i = 0; i < 30; i++) begin
      @(posedge ref_clk);
      #1;
      if (pause_req !== 8'h00) break;
    end
    if (i == 30) begin
      errors++;
      print_verdict();
    end
    chk(pause_req, 8'h08);
    chk(pause_time, t);
  endtask

  task s_reset;
    apb(1'h0, 8'h24, 32'h0);
    chk(rd, 32'h0040_0040);
    apb(1'h0, 8'h44, 32'h0);
    chk(rd, 32'h0000_FFFF);
    apb(1'h0, 8'hF0, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h1);
    chk({tx_ready_oe, rx_ready_oe}, 16'h0);
  endtask

  task s_tx;
    apb(1'h1, 8'h20, 32'h0040_0010);
    @(posedge ref_clk);
    txctl_n <= 1'h0;
    tx_free_lvl <= 72'h010;
    tk(2);
    chk({tx_ready_oe, tx_ready_o}, 16'hFF01);
    @(posedge ref_clk);
    tx_free_lvl <= 72'h00F;
    tk(2);
    chk(tx_ready_o, 8'h00);
    @(posedge ref_clk);
    tx_free_lvl <= 72'h010;
    tx_err_stop <= 8'h01;
    @(posedge ref_clk);
    tx_err_stop <= 8'h00;
    tk(3);
    chk(tx_ready_o, 8'h00);
    apb(1'h1, 8'h08, 32'h0);
    tk(2);
    irq_a = irq;
    apb(1'h1, 8'h08, 32'h0000_FFFF);
    tk(2);
    chk(irq_a, 1'h0);
    chk(irq, 1'h1);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h1);
    tk(2);
    chk(tx_ready_o, 8'h01);
    apb(1'h1, 8'h04, 32'h0000_0100);
    tk(2);
    chk(irq, 1'h0);
    @(posedge ref_clk);
    txctl_n <= 1'h1;
    tk(2);
    chk({tx_ready_oe, tx_ready_o}, 16'h0);
  endtask

  task s_fail;
    @(posedge ref_clk);
    rxctl_n <= 1'h0;
    rx_fill_lvl <= 72'h100_0000;
    rx_started <= 8'h02;
    tk(2);
    chk({rx_ready_oe, rx_ready_o}, 16'hFF04);
    @(posedge ref_clk);
    rx_bad_discard <= 8'h02;
    @(posedge ref_clk);
    rx_bad_discard <= 8'h00;
    #1;
    chk(rx_fail, 1'h1);
    chk(rx_ready_o, 8'h06);
    tk(1);
    chk({rx_fail, rx_ready_o}, 9'h004);
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    apb(1'h1, 8'h04, 32'h2);
    apb(1'h1, 8'h00, 32'h0001_0000);
    @(posedge ref_clk);
    rx_hdr_in <= 8'h01;
    rx_eop_in <= 8'h08;
    tk(2);
    chk(rx_ready_o, 8'h0D);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0D00);
    @(posedge ref_clk);
    rx_hdr_in <= 8'h00;
    rx_eop_in <= 8'h00;
  endtask

  task s_flow;
    @(posedge ref_clk);
    flow_ctl <= 8'h04;
    tk(2);
    chk(force_col, 8'h04);
    @(posedge ref_clk);
    flow_ctl <= 8'h00;
    apb(1'h1, 8'h00, 32'h0000_0808);
    chk(force_col, 8'h00);
    apb(1'h1, 8'h4C, 32'h0000_1234);
    @(posedge ref_clk);
    flow_ctl <= 8'h08;
    wt_pause(16'h1234);
    @(posedge ref_clk);
    flow_ctl <= 8'h00;
    wt_pause(16'h0000);
  endtask

  task s_read;
    hread(1'h0, 1'h1, 1'h0);
    chk({bus_data_oe, bus_data_o}, {1'h1, rx_data_in});
    chk(rx_pop, 8'h20);
    hread(1'h0, 1'h0, 1'h0);
    chk(bus_data_o, rx_status_in);
    hread(1'h0, 1'h0, 1'h1);
    chk({bus_data_oe, rx_pop}, 9'h100);
    hread(1'h1, 1'h0, 1'h0);
    chk({rx_flush, rx_pop}, 16'h2000);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'h1;
    s_reset();
    s_tx();
    s_fail();
    s_flow();
    s_read();
    print_verdict();
  end
endmodule
